// *** rtl/mps_serial_port.sv ***
// Four-mode serial port with multiprocessor ninth-bit addressing.
// Assumes an 8-bit special-function-register bus on the system clock,
// a timer overflow pulse on the same clock, and raw TX/RX pins.
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_serial_port (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_timer_ovf,
    input wire logic i_double_rate,
    input wire logic i_port_int_en,
    input wire logic i_rx,
    output logic o_rx_out,
    output logic o_rx_oe,
    output logic o_tx,
    output logic o_port_irq,
    output logic o_tx_buf_ready
);
    mps_pkg::mps_ctrl_t ctl_reg;
    mps_pkg::mps_ctrl_t ctl_next;
    logic [7:0] rbuf_reg;
    logic [7:0] rbuf_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    mps_pkg::mps_tx_state_t tx_state_reg;
    mps_pkg::mps_tx_state_t tx_state_next;
    logic [10:0] tx_shift_reg;
    logic [10:0] tx_shift_next;
    logic [3:0] tx_bits_reg;
    logic [3:0] tx_bits_next;
    logic [3:0] tx_os_reg;
    logic [3:0] tx_os_next;
    logic tx_pop;
    logic tx_set_done;
    mps_pkg::mps_rx_state_t rx_state_reg;
    mps_pkg::mps_rx_state_t rx_state_next;
    logic [9:0] rx_shift_reg;
    logic [9:0] rx_shift_next;
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_cnt_next;
    logic [3:0] rx_os_reg;
    logic [3:0] rx_os_next;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic rx_prev_reg;
    logic rx_done;
    logic rx_gate;
    logic rx_accept;
    logic [7:0] frame_data;
    logic frame_ninth;
    logic os_tick;
    logic sync_tick;
    logic sync_rise;
    logic sync_high;
    logic buf_push;
    logic buf_valid;
    mps_pkg::mps_txw_t buf_in;
    mps_pkg::mps_txw_t buf_out;

    mps_baud u_baud (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_mode(ctl_reg.mode),
        .i_double_rate(i_double_rate),
        .i_timer_ovf(i_timer_ovf),
        .o_os_tick(os_tick),
        .o_sync_tick(sync_tick),
        .o_sync_rise(sync_rise),
        .o_sync_high(sync_high)
    );

    // Holding buffer lets software queue a second byte while one shifts
    mps_buf2 u_txbuf (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_valid(buf_push),
        .o_ready(o_tx_buf_ready),
        .i_data(buf_in),
        .o_valid(buf_valid),
        .i_ready(tx_pop),
        .o_data(buf_out)
    );

    // Transmit engine; sync mode waits for a shift-clock tick to start
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_bits_next = tx_bits_reg;
        tx_os_next = tx_os_reg;
        tx_pop = 1'b0;
        tx_set_done = 1'b0;
        case (tx_state_reg)
            mps_pkg::MPS_TX_IDLE: begin
                if (buf_valid && rx_state_reg != mps_pkg::MPS_RX_SYNC) begin
                    if (ctl_reg.mode == mps_pkg::MPS_SYNC) begin
                        if (sync_tick) begin
                            tx_pop = 1'b1;
                            tx_shift_next = {3'h7, buf_out.data};
                            tx_bits_next = `MPS_TXB_SYNC;
                            tx_state_next = mps_pkg::MPS_TX_SYNC;
                        end
                    end else if (ctl_reg.mode[1]) begin
                        tx_pop = 1'b1;
                        tx_shift_next = {1'b1, buf_out.ninth, buf_out.data, 1'b0};
                        tx_bits_next = `MPS_TXB_9;
                        tx_os_next = 4'h0;
                        tx_state_next = mps_pkg::MPS_TX_ASYNC;
                    end else begin
                        tx_pop = 1'b1;
                        tx_shift_next = {2'h3, buf_out.data, 1'b0};
                        tx_bits_next = `MPS_TXB_8;
                        tx_os_next = 4'h0;
                        tx_state_next = mps_pkg::MPS_TX_ASYNC;
                    end
                end
            end
            mps_pkg::MPS_TX_ASYNC: begin
                if (os_tick) begin
                    tx_os_next = tx_os_reg + 4'h1;
                    if (tx_os_reg == `MPS_OS_LAST) begin
                        tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                        tx_bits_next = tx_bits_reg - 4'h1;
                        tx_set_done = (tx_bits_reg == 4'h2);
                        if (tx_bits_reg == 4'h1) begin
                            tx_state_next = mps_pkg::MPS_TX_IDLE;
                        end
                    end
                end
            end
            mps_pkg::MPS_TX_SYNC: begin
                if (sync_tick) begin
                    tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                    tx_bits_next = tx_bits_reg - 4'h1;
                    if (tx_bits_reg == 4'h1) begin
                        tx_set_done = 1'b1;
                        tx_state_next = mps_pkg::MPS_TX_IDLE;
                    end
                end
            end
            default: tx_state_next = mps_pkg::MPS_TX_IDLE;
        endcase
    end

    // Receive engine; async start is checked again at mid-bit
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_os_next = rx_os_reg;
        rx_done = 1'b0;
        case (rx_state_reg)
            mps_pkg::MPS_RX_IDLE: begin
                if (ctl_reg.mode == mps_pkg::MPS_SYNC) begin
                    if (!ctl_reg.receive_done_flag && sync_tick
                            && tx_state_reg == mps_pkg::MPS_TX_IDLE) begin
                        rx_state_next = mps_pkg::MPS_RX_SYNC;
                        rx_cnt_next = `MPS_RXB_SYNC;
                        rx_shift_next = 10'h000;
                    end
                end else if (rx_prev_reg && !rx_s2_reg) begin
                    rx_state_next = mps_pkg::MPS_RX_START;
                    rx_os_next = 4'h0;
                end
            end
            mps_pkg::MPS_RX_START: begin
                if (os_tick) begin
                    rx_os_next = rx_os_reg + 4'h1;
                    if (rx_os_reg == `MPS_OS_MID) begin
                        // A glitch shorter than half a bit is not a start
                        rx_state_next = rx_s2_reg ? mps_pkg::MPS_RX_IDLE : mps_pkg::MPS_RX_BITS;
                        rx_os_next = 4'h0;
                        rx_shift_next = 10'h000;
                        rx_cnt_next = ctl_reg.mode[1] ? `MPS_RXB_9 : `MPS_RXB_8;
                    end
                end
            end
            mps_pkg::MPS_RX_BITS: begin
                if (os_tick) begin
                    rx_os_next = rx_os_reg + 4'h1;
                    if (rx_os_reg == `MPS_OS_LAST) begin
                        rx_shift_next = {rx_s2_reg, rx_shift_reg[9:1]};
                        rx_cnt_next = rx_cnt_reg - 4'h1;
                        if (rx_cnt_reg == 4'h1) begin
                            rx_done = 1'b1;
                            rx_state_next = mps_pkg::MPS_RX_IDLE;
                        end
                    end
                end
            end
            mps_pkg::MPS_RX_SYNC: begin
                if (sync_rise) begin
                    rx_shift_next = {rx_s2_reg, rx_shift_reg[9:1]};
                    rx_cnt_next = rx_cnt_reg - 4'h1;
                    if (rx_cnt_reg == 4'h1) begin
                        rx_done = 1'b1;
                        rx_state_next = mps_pkg::MPS_RX_IDLE;
                    end
                end
            end
            default: rx_state_next = mps_pkg::MPS_RX_IDLE;
        endcase
        if (!ctl_reg.rx_enable) begin
            rx_state_next = mps_pkg::MPS_RX_IDLE;
        end
    end

    // Frame unpacking and multiprocessor gating per mode
    always_comb begin
        case (ctl_reg.mode)
            mps_pkg::MPS_SYNC: begin
                frame_data = rx_shift_next[9:2];
                frame_ninth = ctl_reg.receive_ninth;
                rx_gate = 1'b1;
            end
            mps_pkg::MPS_ASYNC8: begin
                frame_data = rx_shift_next[8:1];
                frame_ninth = rx_shift_next[9];
                rx_gate = !ctl_reg.multiproc_enable || rx_shift_next[9];
            end
            default: begin
                frame_data = rx_shift_next[7:0];
                frame_ninth = rx_shift_next[8];
                rx_gate = !ctl_reg.multiproc_enable || rx_shift_next[8];
            end
        endcase
        rx_accept = rx_done && rx_gate && !ctl_reg.receive_done_flag;
    end

    // Register file; hardware flag set wins over a same-cycle software clear
    always_comb begin
        ctl_next = ctl_reg;
        rbuf_next = rbuf_reg;
        rdata_next = rdata_reg;
        buf_push = i_sfr_wr && (i_sfr_addr == `MPS_ADDR_DATA);
        buf_in = '{ninth: ctl_reg.transmit_ninth, data: i_sfr_wdata};
        if (i_sfr_wr && i_sfr_addr == `MPS_ADDR_CTRL) begin
            ctl_next = mps_pkg::mps_ctrl_t'(i_sfr_wdata);
        end
        if (tx_set_done) begin
            ctl_next.transmit_done_flag = 1'b1;
        end
        if (rx_accept) begin
            ctl_next.receive_done_flag = 1'b1;
            ctl_next.receive_ninth = frame_ninth;
            rbuf_next = frame_data;
        end
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                `MPS_ADDR_CTRL: rdata_next = ctl_reg;
                `MPS_ADDR_DATA: rdata_next = rbuf_reg;
                default: rdata_next = 8'h00;
            endcase
        end
        irq_next = i_port_int_en
            && (ctl_reg.transmit_done_flag || ctl_reg.receive_done_flag);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_reg <= `MPS_CTRL_RST;
            rbuf_reg <= `MPS_DATA_RST;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            tx_state_reg <= mps_pkg::MPS_TX_IDLE;
            tx_shift_reg <= 11'h7ff;
            tx_bits_reg <= 4'h0;
            tx_os_reg <= 4'h0;
            rx_state_reg <= mps_pkg::MPS_RX_IDLE;
            rx_shift_reg <= 10'h000;
            rx_cnt_reg <= 4'h0;
            rx_os_reg <= 4'h0;
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            ctl_reg <= ctl_next;
            rbuf_reg <= rbuf_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_bits_reg <= tx_bits_next;
            tx_os_reg <= tx_os_next;
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_os_reg <= rx_os_next;
            rx_s1_reg <= i_rx;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
        end
    end

    // Pins: sync mode puts data open-drain on RX and the shift clock on TX
    always_comb begin
        o_sfr_rdata = rdata_reg;
        o_port_irq = irq_reg;
        o_rx_out = 1'b0;
        o_rx_oe = (tx_state_reg == mps_pkg::MPS_TX_SYNC) && !tx_shift_reg[0];
        if (tx_state_reg == mps_pkg::MPS_TX_SYNC || rx_state_reg == mps_pkg::MPS_RX_SYNC) begin
            o_tx = sync_high;
        end else begin
            o_tx = tx_shift_reg[0];
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    logic tx9_seen_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx9_seen_reg <= 1'b0;
        end else if (tx_pop) begin
            tx9_seen_reg <= buf_out.ninth;
        end
    end

    sequence s_stop_begins;
        tx_state_reg == mps_pkg::MPS_TX_ASYNC && os_tick
            && tx_os_reg == `MPS_OS_LAST && tx_bits_reg == 4'h2;
    endsequence
    sequence s_frame_end_9;
        rx_done && ctl_reg.mode[1] && !ctl_reg.receive_done_flag;
    endsequence

    chk_addr_filter: assert property ((s_frame_end_9 and (ctl_reg.multiproc_enable
        && !rx_shift_next[8])) |=> !ctl_reg.receive_done_flag)
        else $error("address filter let a data frame through");
    chk_mp_off_take: assert property ((s_frame_end_9 and !ctl_reg.multiproc_enable)
        |=> ctl_reg.receive_done_flag && rbuf_reg == $past(rx_shift_next[7:0]))
        else $error("frame lost with multiprocessor enable clear");
    chk_stop_gate: assert property (rx_done && ctl_reg.mode == mps_pkg::MPS_ASYNC8
        && ctl_reg.multiproc_enable && !rx_shift_next[9] |=> $stable(rbuf_reg))
        else $error("bad stop bit loaded the buffer");
    chk_rx_off_idle: assert property (!ctl_reg.rx_enable |=> rx_state_reg == mps_pkg::MPS_RX_IDLE)
        else $error("receiver active while disabled");
    chk_ninth_on_pin: assert property (tx_state_reg == mps_pkg::MPS_TX_ASYNC
        && ctl_reg.mode[1] && tx_bits_reg == 4'h2 |-> o_tx == tx9_seen_reg)
        else $error("ninth bit on line differs from queued value");
    chk_ti_at_stop: assert property (s_stop_begins |=> ctl_reg.transmit_done_flag
        ##0 o_tx == 1'b1)
        else $error("transmit flag not set at stop bit start");
    chk_flags_sticky: assert property (ctl_reg.receive_done_flag
        && !(i_sfr_wr && i_sfr_addr == `MPS_ADDR_CTRL) |=> ctl_reg.receive_done_flag)
        else $error("receive flag cleared without software");
    chk_irq_follows: assert property ($rose(ctl_reg.transmit_done_flag) && i_port_int_en
        ##1 i_port_int_en |-> o_port_irq)
        else $error("interrupt request missing after flag");
    chk_discard_full: assert property (rx_done && ctl_reg.receive_done_flag
        && !(i_sfr_wr && i_sfr_addr == `MPS_ADDR_CTRL)
        |=> $stable(rbuf_reg) && $stable(ctl_reg.receive_ninth))
        else $error("frame overwrote unread data");
    chk_read_rbuf: assert property (i_sfr_rd && i_sfr_addr == `MPS_ADDR_DATA
        |=> o_sfr_rdata == $past(rbuf_reg))
        else $error("data read did not return receive buffer");
endmodule : mps_serial_port

// *** rtl/mps_consts.svh ***
// Constants of the multiprocessor serial port: offsets, resets, counts.
// Assumes inclusion by bare name from every design file.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
`define MPS_ADDR_CTRL 8'h98
`define MPS_ADDR_DATA 8'h99
`define MPS_CTRL_RST 8'h00
`define MPS_DATA_RST 8'h00
`define MPS_SYNC_LAST 4'hb
`define MPS_SYNC_RISE 4'h5
`define MPS_FIX_LAST_SLOW 2'h3
`define MPS_FIX_LAST_FAST 2'h1
`define MPS_OS_MID 4'h7
`define MPS_OS_LAST 4'hf
`define MPS_TXB_SYNC 4'h8
`define MPS_TXB_8 4'ha
`define MPS_TXB_9 4'hb
`define MPS_RXB_SYNC 4'h8
`define MPS_RXB_8 4'h9
`define MPS_RXB_9 4'ha
`define MPS_BUF_DEPTH 2'h2
`endif

// *** rtl/mps_pkg.sv ***
// Types of the multiprocessor serial port.
// Assumes nothing; used by every design file through scoped names.
package mps_pkg;
    typedef enum logic [1:0] {
        MPS_SYNC = 2'b00,
        MPS_ASYNC8 = 2'b01,
        MPS_FIX9 = 2'b10,
        MPS_VAR9 = 2'b11
    } mps_mode_t;
    // Control register layout, bit 7 first
    typedef struct packed {
        mps_mode_t mode;
        logic multiproc_enable;
        logic rx_enable;
        logic transmit_ninth;
        logic receive_ninth;
        logic transmit_done_flag;
        logic receive_done_flag;
    } mps_ctrl_t;
    // One queued transmit word
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } mps_txw_t;
    typedef enum logic [1:0] {
        MPS_TX_IDLE = 2'b00,
        MPS_TX_ASYNC = 2'b01,
        MPS_TX_SYNC = 2'b10
    } mps_tx_state_t;
    typedef enum logic [1:0] {
        MPS_RX_IDLE = 2'b00,
        MPS_RX_START = 2'b01,
        MPS_RX_BITS = 2'b10,
        MPS_RX_SYNC = 2'b11
    } mps_rx_state_t;
endpackage : mps_pkg

// *** rtl/mps_baud.sv ***
// Rate enables for the serial port: sync shift clock and 16x oversample tick.
// Assumes a timer overflow pulse on the system clock from the timer block.
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_baud (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire mps_pkg::mps_mode_t i_mode,
    input wire logic i_double_rate,
    input wire logic i_timer_ovf,
    output logic o_os_tick,
    output logic o_sync_tick,
    output logic o_sync_rise,
    output logic o_sync_high
);
    logic [3:0] sync_cnt_reg;
    logic [3:0] sync_cnt_next;
    logic [1:0] pre_cnt_reg;
    logic [1:0] pre_cnt_next;
    logic [1:0] pre_last;
    logic ovf_half_reg;
    logic ovf_half_next;

    // Divide by twelve for sync, by 2 or 4 for fixed rate, halve overflows at normal rate
    always_comb begin
        pre_last = i_double_rate ? `MPS_FIX_LAST_FAST : `MPS_FIX_LAST_SLOW;
        sync_cnt_next = (sync_cnt_reg == `MPS_SYNC_LAST) ? 4'h0 : sync_cnt_reg + 4'h1;
        pre_cnt_next = (pre_cnt_reg >= pre_last) ? 2'h0 : pre_cnt_reg + 2'h1;
        ovf_half_next = i_timer_ovf ? ~ovf_half_reg : ovf_half_reg;
        if (i_mode == mps_pkg::MPS_FIX9) begin
            o_os_tick = (pre_cnt_reg >= pre_last);
        end else begin
            // Double rate passes every overflow: clock / (16 * (256 - reload))
            o_os_tick = i_timer_ovf && (i_double_rate || ovf_half_reg);
        end
        o_sync_tick = (sync_cnt_reg == `MPS_SYNC_LAST);
        o_sync_rise = (sync_cnt_reg == `MPS_SYNC_RISE);
        o_sync_high = (sync_cnt_reg > `MPS_SYNC_RISE);
    end

    // Dividers free-run; phase alignment is taken at frame start
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_cnt_reg <= 4'h0;
            pre_cnt_reg <= 2'h0;
            ovf_half_reg <= 1'b0;
        end else begin
            sync_cnt_reg <= sync_cnt_next;
            pre_cnt_reg <= pre_cnt_next;
            ovf_half_reg <= ovf_half_next;
        end
    end
endmodule : mps_baud

// *** rtl/mps_buf2.sv ***
// Two-entry transmit holding buffer with valid/ready on both sides.
// Assumes source and sink share the system clock.
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_buf2 (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire mps_pkg::mps_txw_t i_data,
    output logic o_valid,
    input wire logic i_ready,
    output mps_pkg::mps_txw_t o_data
);
    mps_pkg::mps_txw_t mem_reg [2];
    mps_pkg::mps_txw_t mem_next [2];
    logic wr_ptr_reg;
    logic wr_ptr_next;
    logic rd_ptr_reg;
    logic rd_ptr_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic push;
    logic pop;

    // Pointer and count update; full refuses, empty withholds
    always_comb begin
        o_ready = (cnt_reg != `MPS_BUF_DEPTH);
        o_valid = (cnt_reg != 2'h0);
        o_data = mem_reg[rd_ptr_reg];
        push = i_valid && o_ready;
        pop = o_valid && i_ready;
        mem_next = mem_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = i_data;
        end
        wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
        rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : mps_buf2

// *** verif/mps_far_port.sv ***
// Far-end nine-bit serial port: sends frames on RX, collects frames from TX.
// Assumes mode 2 at normal rate, so one bit lasts 64 system clocks.
`timescale 1ns/1ps
module mps_far_port (
    input wire logic i_clk_sys,
    input wire logic i_tx,
    output logic o_rx
);
    localparam int BIT_CLKS = 64;
    // Line idles high between frames, as a released line with pull-up
    initial o_rx = 1'b1;
    // Start, eight data LSB first, ninth, stop
    task automatic send(input logic [8:0] w);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge i_clk_sys) o_rx = f[i];
            repeat (BIT_CLKS - 1) @(negedge i_clk_sys);
        end
    endtask : send
    // Mid-bit sampling; returns {stop, ninth, data}
    task automatic grab(output logic [9:0] w);
        @(negedge i_tx);
        repeat (BIT_CLKS / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk_sys);
            w[i] = i_tx;
        end
    endtask : grab
endmodule : mps_far_port

// *** verif/multiprocessor_serial_port_tb.sv ***
// Bench for the serial port: registers, multiprocessor receive, transmit.
// Assumes normal rate in modes 2 and 1; timer overflow used only in mode 1.
`timescale 1ns/1ps
module multiprocessor_serial_port_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rx;
    logic tx;
    logic irq;
    logic [7:0] got;
    logic [9:0] frame;
    logic [7:0] exp_rx;
    logic [7:0] exp_tx;
    logic ovf = 1'b0;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    // Overflow every second clock: mode 1 bit time then matches the far port
    always @(negedge i_clk_sys) ovf <= ~ovf;
    mps_serial_port mps_serial_port_inst (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_timer_ovf(ovf),
        .i_double_rate(1'b0), .i_port_int_en(1'b1), .i_rx(rx), .o_rx_out(),
        .o_rx_oe(), .o_tx(tx), .o_port_irq(irq), .o_tx_buf_ready()
    );
    mps_far_port mps_far_port_inst (.i_clk_sys(i_clk_sys), .i_tx(tx), .o_rx(rx));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One-cycle strobes, launched off the sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clk_sys);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        addr = a;
        rd = 1'b1;
        @(negedge i_clk_sys);
        rd = 1'b0;
        chk(rdata, e);
    endtask : rd_chk
    task automatic stop_test();
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // Hang guard: seven frames need well under this
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(99811));
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        rd_chk(8'h98, 8'h00);
        rd_chk(8'h99, 8'h00);
        wr_reg(8'h98, 8'hb0);
        exp_rx = 8'($urandom);
        mps_far_port_inst.send({1'b0, ~exp_rx});
        rd_chk(8'h98, 8'hb0);
        mps_far_port_inst.send({1'b1, exp_rx});
        rd_chk(8'h98, 8'hb5);
        rd_chk(8'h99, exp_rx);
        chk({7'h00, irq}, 8'h01);
        // Flag still set, so this frame must be dropped
        mps_far_port_inst.send({1'b1, ~exp_rx});
        rd_chk(8'h99, exp_rx);
        rd_chk(8'h98, 8'hb5);
        wr_reg(8'h98, 8'h90);
        exp_rx = 8'($urandom);
        mps_far_port_inst.send({1'b0, exp_rx});
        rd_chk(8'h98, 8'h91);
        rd_chk(8'h99, exp_rx);
        // Mode 1, stop check on: ninth bit of the far frame lands as stop
        wr_reg(8'h98, 8'h70);
        mps_far_port_inst.send({1'b0, ~exp_rx});
        rd_chk(8'h98, 8'h70);
        exp_rx = 8'($urandom);
        mps_far_port_inst.send({1'b1, exp_rx});
        rd_chk(8'h98, 8'h75);
        rd_chk(8'h99, exp_rx);
        // Receiver off, ninth bit one, then one byte out
        wr_reg(8'h98, 8'h88);
        exp_tx = 8'($urandom);
        fork
            mps_far_port_inst.grab(frame);
            wr_reg(8'h99, exp_tx);
        join
        chk(frame[7:0], exp_tx);
        chk({6'h00, frame[9:8]}, 8'h03);
        rd_chk(8'h98, 8'h8a);
        rd_chk(8'h99, exp_rx);
        stop_test();
    end
endmodule : multiprocessor_serial_port_tb
